// ### acp_pkg.sv
// Shared constants and types for the converter correction and DMA block.
package acp_pkg;
    // Register word indices; the byte address is four times the index.
    localparam logic [3:0] REG_CFG    = 4'h0;
    localparam logic [3:0] REG_OFFSET = 4'h1;
    localparam logic [3:0] REG_GAIN   = 4'h2;
    localparam logic [3:0] REG_DATA   = 4'h3;
    localparam logic [3:0] REG_FLAG   = 4'h4;
    localparam logic [3:0] REG_DMACFG = 4'h5;
    localparam logic [3:0] REG_DMABEG = 4'h6;
    localparam logic [3:0] REG_DMALEN = 4'h7;
    localparam logic [3:0] REG_DMACUR = 4'h8;
    localparam logic [3:0] REG_PINCFG = 4'h9;
    localparam logic [3:0] REG_PININ  = 4'hA;
    // Field positions in the configuration register.
    localparam int CFG_EN   = 0;
    localparam int CFG_PBUF = 1;
    localparam int CFG_NBUF = 2;
    localparam int CFG_MUXN = 4;
    localparam int CFG_MUXP = 8;
    // Event flag positions.
    localparam int FLG_DATA = 0;
    localparam int FLG_HALF = 1;
    localparam int FLG_FULL = 2;
    localparam int FLG_SAT  = 3;
    localparam int FLG_OVF  = 4;
    // DMA control positions.
    localparam int DMA_LOAD = 0;
    localparam int DMA_WRAP = 1;
    localparam int DMA_RST  = 4;
    // Reset values and fixed constants.
    localparam logic [15:0] OFFSET_RST = 16'h0000;
    localparam logic [15:0] GAIN_RST   = 16'h8000;
    localparam logic [27:0] PINCFG_RST = 28'h444_4444;
    localparam logic [3:0]  PIN_ANALOG = 4'h0;
    localparam logic [15:0] SAT_MAX    = 16'h7FFF;
    localparam logic [15:0] SAT_MIN    = 16'h8000;
    localparam int GAIN_FRAC = 15;
    localparam int NUM_PINS  = 7;
    localparam int VREF_PIN  = 6;
    // One half-word store towards system RAM.
    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] data;
    } acp_dma_wr_t;
    typedef enum logic [1:0] {
        DMA_IDLE,
        DMA_RUN,
        DMA_WRITE,
        DMA_DONE
    } acp_dma_st_t;
endpackage : acp_pkg

// ### acp_adc_dma.sv
// Converter input control, offset and gain correction, and sample DMA.
// What this block does
// - Analog pins lose digital function and read back as one.
// - Internal reference drives its pin only when enabled and pin analog.
// - First step adds the signed raw result to the signed offset.
// - Multiply by gain; clamp to 0x7FFF or 0x8000 and flag saturation.
// - The corrected value is halved to give the final result.
// - Gain is unsigned: bit 15 integer, bits 14 to 0 fraction.
// - Reset leaves offset at zero and gain at 0x8000.
// - DMA stores corrected results, never raw ones.
// - Buffer length counts 16-bit samples.
// - DMA is reset first, then started by the load bit.
// - Mode bit: 0 linear, 1 auto-wrap.
// - Linear mode stops after the set count and sets the full flag.
// - After linear full, a result before reset or disable sets overflow.
// - Auto-wrap returns to the start and runs until disable or reset.
// - Half flag after the lower half, full flag after the upper half.
// - A readable pointer shows the location being written.
// - Input selector codes: 0-5 external, 8-11 internal, others nothing.
// - Input buffers have gain 0.25; the block does not rescale the data for it.
// - Separate enable bits for positive and negative input buffers.
// - Once enabled the converter converts continuously until disabled.
// - Writing one clears an event flag; zero leaves it.
module acp_adc_dma
    import acp_pkg::*;
(
    // Clock and reset.
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // Avalon-MM register slave.
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // Analog converter.
    input  wire logic              conv_valid,
    input  wire logic [15:0]       conv_data,
    output logic                   conv_enable,
    output logic [5:0]             pos_ext_sel,
    output logic [3:0]             pos_int_sel,
    output logic [5:0]             neg_ext_sel,
    output logic [3:0]             neg_int_sel,
    output logic                   positive_buffer_enable,
    output logic                   negative_buffer_enable,
    output logic                   vref_out_enable,
    // Analog-capable pins.
    input  wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0]    pin_digital_off,
    // DMA write master towards RAM.
    output logic                   dma_valid,
    output acp_dma_wr_t            dma_wr,
    input  wire logic              dma_ready
);
    // Bus slave.
    logic [31:0]         rdata_ff;
    logic                wait_ff;

    // Settings written by software.
    logic [11:0]         cfg_ff;
    logic [15:0]         offset_ff;
    logic [15:0]         gain_ff;

    // Latest result and event flags.
    logic [15:0]         result_ff;
    logic                res_valid_ff;
    logic                res_sat_ff;
    logic [4:0]          flags_ff;

    // Sample DMA channel.
    logic                wrap_ff;
    logic                armed_ff;
    logic [31:0]         beg_ff;
    logic [15:0]         len_ff;
    logic [15:0]         count_ff;

    // Pins and input selectors.
    logic [27:0]         pincfg_ff;
    logic [NUM_PINS-1:0] analog_ff;
    logic [5:0]          pos_ext_ff;
    logic [3:0]          pos_int_ff;
    logic [5:0]          neg_ext_ff;
    logic [3:0]          neg_int_ff;
    logic                vref_ff;

    // Store towards RAM.
    logic                dma_valid_ff;
    acp_dma_wr_t         dma_wr_ff;
    acp_dma_st_t         st_ff;

    // Next values and strobes.
    logic                wr_acc;
    logic [16:0]         nxt_sum;
    logic [33:0]         nxt_prod;
    logic [33:0]         nxt_scaled;
    logic [15:0]         nxt_gained;
    logic                nxt_sat;
    logic [4:0]          nxt_set;
    logic [4:0]          nxt_clr;
    logic [31:0]         nxt_rdata;
    logic [15:0]         nxt_count;
    logic                dma_rst_wr;
    logic                dma_load_wr;
    logic                last_wr;
    logic                half_wr;
    logic [31:0]         cur_ptr;

    // Accesses complete one cycle after they appear; waitrequest is high
    // while idle, which the bus allows and keeps the output a plain flop.
    // A write takes effect at the edge that completes it, never earlier.
    assign wr_acc = avs_write && !wait_ff;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wait_ff <= 1'b1;
        end else if ((avs_read || avs_write) && wait_ff) begin
            wait_ff <= 1'b0;
        end else begin
            wait_ff <= 1'b1;
        end
    end

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (avs_address)
            REG_CFG:    nxt_rdata[11:0] = cfg_ff;
            REG_OFFSET: nxt_rdata[15:0] = offset_ff;
            REG_GAIN:   nxt_rdata[15:0] = gain_ff;
            REG_DATA:   nxt_rdata[15:0] = result_ff;
            REG_FLAG:   nxt_rdata[4:0]  = flags_ff;
            REG_DMACFG: begin
                nxt_rdata[DMA_LOAD] = (st_ff == DMA_RUN)
                                   || (st_ff == DMA_WRITE);
                nxt_rdata[DMA_WRAP] = wrap_ff;
            end
            REG_DMABEG: nxt_rdata = beg_ff;
            REG_DMALEN: nxt_rdata[15:0] = len_ff;
            REG_DMACUR: nxt_rdata = cur_ptr;
            REG_PINCFG: nxt_rdata[27:0] = pincfg_ff;
            REG_PININ:  nxt_rdata[NUM_PINS-1:0] = pin_in | analog_ff;
            default:    nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the wait cycle, so it stands at the edge
    // where the master samples waitrequest low.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read && wait_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Configuration registers.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_ff    <= 12'h000;
            offset_ff <= OFFSET_RST;
            gain_ff   <= GAIN_RST;
            beg_ff    <= 32'h0000_0000;
            len_ff    <= 16'h0000;
            wrap_ff   <= 1'b0;
            pincfg_ff <= PINCFG_RST;
        end else if (wr_acc) begin
            unique case (avs_address)
                REG_CFG:    cfg_ff    <= avs_writedata[11:0];
                REG_OFFSET: offset_ff <= avs_writedata[15:0];
                REG_GAIN:   gain_ff   <= avs_writedata[15:0];
                REG_DMABEG: beg_ff    <= avs_writedata;
                REG_DMALEN: len_ff    <= avs_writedata[15:0];
                REG_DMACFG: wrap_ff   <= avs_writedata[DMA_WRAP];
                REG_PINCFG: pincfg_ff <= avs_writedata[27:0];
                default: begin
                end
            endcase
        end
    end

    // Pin mode decode and the reference output gate.
    // Both decode the same pin fields, so they change on the same edge.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            analog_ff <= '0;
            vref_ff   <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                analog_ff[i] <= pincfg_ff[4*i +: 4] == PIN_ANALOG;
            end
            vref_ff <= cfg_ff[CFG_EN]
                    && pincfg_ff[4*VREF_PIN +: 4] == PIN_ANALOG;
        end
    end

    // Selector decode; unlisted codes leave every switch open.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pos_ext_ff <= 6'h00;
            pos_int_ff <= 4'h0;
            neg_ext_ff <= 6'h00;
            neg_int_ff <= 4'h0;
        end else begin
            pos_ext_ff <= 6'h00;
            pos_int_ff <= 4'h0;
            neg_ext_ff <= 6'h00;
            neg_int_ff <= 4'h0;
            if (cfg_ff[CFG_MUXP+3 -: 4] < 4'h6) begin
                pos_ext_ff[cfg_ff[CFG_MUXP+2 -: 3]] <= 1'b1;
            end else if (cfg_ff[CFG_MUXP+3 -: 2] == 2'b10) begin
                pos_int_ff[cfg_ff[CFG_MUXP+1 -: 2]] <= 1'b1;
            end
            if (cfg_ff[CFG_MUXN+3 -: 4] < 4'h6) begin
                neg_ext_ff[cfg_ff[CFG_MUXN+2 -: 3]] <= 1'b1;
            end else if (cfg_ff[CFG_MUXN+3 -: 2] == 2'b10) begin
                neg_int_ff[cfg_ff[CFG_MUXN+1 -: 2]] <= 1'b1;
            end
        end
    end

    // Correction arithmetic, done in one cycle since samples are slow.
    always_comb begin
        nxt_sum = {conv_data[15], conv_data}
                + {offset_ff[15], offset_ff};
        nxt_prod = $signed(nxt_sum) * $signed({1'b0, gain_ff});
        nxt_scaled = $signed(nxt_prod) >>> GAIN_FRAC;
        nxt_sat = 1'b0;
        nxt_gained = nxt_scaled[15:0];
        // Everything above the low sixteen bits must copy the sign bit,
        // otherwise the product has left the signed sixteen-bit range.
        if (!nxt_scaled[33] && nxt_scaled[32:15] != 18'h0_0000) begin
            nxt_gained = SAT_MAX;
            nxt_sat    = 1'b1;
        end else if (nxt_scaled[33] && nxt_scaled[32:15] != 18'h3_FFFF) begin
            nxt_gained = SAT_MIN;
            nxt_sat    = 1'b1;
        end
    end

    // Results arrive only while the converter is enabled.
    // A strobe seen while disabled is ignored, as the converter is off.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            result_ff    <= 16'h0000;
            res_valid_ff <= 1'b0;
            res_sat_ff   <= 1'b0;
        end else begin
            res_valid_ff <= conv_valid && cfg_ff[CFG_EN];
            res_sat_ff   <= 1'b0;
            if (conv_valid && cfg_ff[CFG_EN]) begin
                result_ff  <= {nxt_gained[15], nxt_gained[15:1]};
                res_sat_ff <= nxt_sat;
            end
        end
    end

    // DMA control strobes; the load bit only starts a channel that was
    // reset since its last run.
    assign dma_rst_wr  = wr_acc && avs_address == REG_DMACFG
                      && avs_writedata[DMA_RST];
    assign dma_load_wr = wr_acc && avs_address == REG_DMACFG
                      && avs_writedata[DMA_LOAD] && armed_ff;
    assign nxt_count   = count_ff + 16'h0001;
    assign last_wr     = nxt_count >= len_ff;
    assign half_wr     = nxt_count == {1'b0, len_ff[15:1]};
    // Byte address of the next store; it doubles as the pointer register.
    assign cur_ptr     = beg_ff + {15'h0000, count_ff, 1'b0};

    // The start consumes the arming, so a second load without a fresh
    // reset cannot restart a channel that has already filled its buffer.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            armed_ff <= 1'b0;
        end else if (dma_rst_wr) begin
            armed_ff <= 1'b1;
        end else if (dma_load_wr) begin
            armed_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_ff        <= DMA_IDLE;
            count_ff     <= 16'h0000;
            dma_valid_ff <= 1'b0;
            dma_wr_ff    <= '0;
        end else if (dma_rst_wr) begin
            st_ff        <= DMA_IDLE;
            count_ff     <= 16'h0000;
            dma_valid_ff <= 1'b0;
        end else begin
            unique case (st_ff)
                DMA_IDLE: begin
                    if (dma_load_wr) begin
                        st_ff <= DMA_RUN;
                    end
                end
                DMA_RUN: begin
                    if (res_valid_ff) begin
                        dma_valid_ff   <= 1'b1;
                        dma_wr_ff.data <= result_ff;
                        dma_wr_ff.addr <= cur_ptr;
                        st_ff <= DMA_WRITE;
                    end
                end
                DMA_WRITE: begin
                    // No queue: a result landing now is lost and flagged.
                    if (dma_ready) begin
                        dma_valid_ff <= 1'b0;
                        if (!last_wr) begin
                            count_ff <= nxt_count;
                            st_ff    <= DMA_RUN;
                        end else if (wrap_ff) begin
                            count_ff <= 16'h0000;
                            st_ff    <= DMA_RUN;
                        end else begin
                            // The pointer still moves past the last
                            // sample, so it reads as the buffer end.
                            count_ff <= nxt_count;
                            st_ff    <= DMA_DONE;
                        end
                    end
                end
                DMA_DONE: begin
                end
            endcase
        end
    end

    // Event flags; a set in the same cycle as a clear wins.
    always_comb begin
        nxt_set = 5'h00;
        nxt_set[FLG_DATA] = res_valid_ff;
        nxt_set[FLG_SAT]  = res_sat_ff;
        nxt_set[FLG_HALF] = st_ff == DMA_WRITE && dma_ready
                         && half_wr;
        nxt_set[FLG_FULL] = st_ff == DMA_WRITE && dma_ready
                         && last_wr;
        // A sample with nowhere to go is lost and reported.
        nxt_set[FLG_OVF]  = res_valid_ff && cfg_ff[CFG_EN]
                         && (st_ff == DMA_DONE
                          || st_ff == DMA_WRITE);
        nxt_clr = 5'h00;
        if (wr_acc && avs_address == REG_FLAG) begin
            nxt_clr = avs_writedata[4:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flags_ff <= 5'h00;
        end else begin
            flags_ff <= (flags_ff & ~nxt_clr) | nxt_set;
        end
    end

    assign avs_readdata           = rdata_ff;
    assign avs_waitrequest        = wait_ff;
    assign conv_enable            = cfg_ff[CFG_EN];
    assign positive_buffer_enable = cfg_ff[CFG_PBUF];
    assign negative_buffer_enable = cfg_ff[CFG_NBUF];
    assign vref_out_enable        = vref_ff;
    assign pos_ext_sel            = pos_ext_ff;
    assign pos_int_sel            = pos_int_ff;
    assign neg_ext_sel            = neg_ext_ff;
    assign neg_int_sel            = neg_int_ff;
    assign pin_digital_off        = analog_ff;
    assign dma_valid              = dma_valid_ff;
    assign dma_wr                 = dma_wr_ff;
endmodule : acp_adc_dma

// ### acp_adc_dma_assertions.sv
// Port-level assertions for the converter correction and DMA block.
module acp_adc_dma_assertions
    import acp_pkg::*;
(
    // Clock and reset.
    input wire logic         mclk,
    input wire logic         rst_n,
    // Register bus.
    input wire logic         avs_read,
    input wire logic         avs_write,
    input wire logic         avs_waitrequest,
    // Converter side.
    input wire logic         conv_valid,
    input wire logic         conv_enable,
    input wire logic [5:0]   pos_ext_sel,
    input wire logic [3:0]   pos_int_sel,
    input wire logic [5:0]   neg_ext_sel,
    input wire logic [3:0]   neg_int_sel,
    input wire logic         positive_buffer_enable,
    input wire logic         negative_buffer_enable,
    input wire logic         vref_out_enable,
    input wire logic [NUM_PINS-1:0] pin_digital_off,
    // DMA side.
    input wire logic         dma_valid,
    input wire acp_dma_wr_t  dma_wr,
    input wire logic         dma_ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_wait_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_idle: assert property (
        !(avs_read || avs_write) |=> avs_waitrequest)
        else $error("bus answered without a request");
    a_dma_hold: assert property (
        dma_valid && !dma_ready |=> dma_valid && $stable(dma_wr))
        else $error("store dropped or changed before acceptance");
    a_dma_even: assert property (
        dma_valid |-> !dma_wr.addr[0])
        else $error("store address not half-word aligned");
    a_dma_cause: assert property (
        $rose(dma_valid) |-> $past(conv_valid, 2) || $past(conv_valid, 3))
        else $error("store raised without a conversion");
    a_vref_cause: assert property (
        vref_out_enable |-> (conv_enable || $past(conv_enable))
        && (pin_digital_off[VREF_PIN] || $past(pin_digital_off[VREF_PIN])))
        else $error("reference driven while disabled or pin digital");
    a_sel_onehot: assert property (
        $onehot0({pos_ext_sel, pos_int_sel})
        && $onehot0({neg_ext_sel, neg_int_sel}))
        else $error("input selector drives two sources");
    a_buf_cause: assert property (
        $changed({positive_buffer_enable, negative_buffer_enable})
        |-> $past(avs_write) || $past(avs_write, 2))
        else $error("buffer enable changed without a write");

    c_dma_store: cover property (dma_valid && dma_ready);
    c_vref_on: cover property (vref_out_enable);
    c_read_done: cover property (avs_read && !avs_waitrequest);
endmodule : acp_adc_dma_assertions

bind acp_adc_dma acp_adc_dma_assertions chk (
    .mclk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .conv_valid,
    .conv_enable, .pos_ext_sel, .pos_int_sel, .neg_ext_sel, .neg_int_sel,
    .positive_buffer_enable, .negative_buffer_enable, .vref_out_enable,
    .pin_digital_off, .dma_valid, .dma_wr, .dma_ready
);

// ### acp_ram_model.sv
// Behavioural system RAM taking half-word stores from the sample DMA.
module acp_ram_model
    import acp_pkg::*;
(
    // Clock and reset.
    input wire logic         mclk,
    input wire logic         rst_n,
    // Stretches acceptance so that a held store is really checked.
    input wire logic         slow,
    // Store port.
    input wire logic         dma_valid,
    input wire acp_dma_wr_t  dma_wr,
    output logic             dma_ready
);
    logic [15:0] mem [logic [31:0]];
    logic [1:0]  wait_ff;
    int          n_wr;
    initial begin
        n_wr = 0;
        dma_ready = 1'b0;
        wait_ff = 2'h0;
    end
    always @(posedge mclk) begin
        if (!rst_n) begin
            dma_ready <= 1'b0;
            wait_ff <= 2'h0;
        end else if (dma_valid && dma_ready) begin
            mem[dma_wr.addr] = dma_wr.data;
            n_wr = n_wr + 1;
            dma_ready <= 1'b0;
            wait_ff <= 2'h0;
        end else if (dma_valid) begin
            wait_ff <= wait_ff + 2'h1;
            dma_ready <= !slow || (wait_ff == 2'h2);
        end
    end
endmodule : acp_ram_model

// ### acp_adc_dma_tb.sv
// Self-checking bench for the converter correction and sample DMA block.
module acp_adc_dma_tb
    import acp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv;
    logic avs_waitrequest, conv_valid = 1'b0, conv_enable, slow = 1'b0;
    logic [15:0] conv_data = 16'h0;
    logic [5:0] pos_ext_sel, neg_ext_sel;
    logic [3:0] pos_int_sel, neg_int_sel;
    logic positive_buffer_enable, negative_buffer_enable, vref_out_enable;
    logic [6:0] pin_in = 7'h12, pin_digital_off;
    logic dma_valid, dma_ready;
    acp_dma_wr_t dma_wr;
    int n_mismatch = 0, checked = 0, cyc = 0;
    logic [15:0] rt[5] = '{16'h1000, 16'h0100, 16'hF000, 16'h9000, 16'h7000};
    logic [15:0] ot[5] = '{16'h0000, 16'hFF00, 16'h0010, 16'hF000, 16'h0000};
    logic [15:0] gt[5] = '{16'h8000, 16'h8000, 16'hC000, 16'hFFFF, 16'hFFFF};

    acp_adc_dma uut (
        .mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .conv_valid, .conv_data,
        .conv_enable, .pos_ext_sel, .pos_int_sel, .neg_ext_sel, .neg_int_sel,
        .positive_buffer_enable, .negative_buffer_enable, .vref_out_enable,
        .pin_in, .pin_digital_off, .dma_valid, .dma_wr, .dma_ready
    );
    acp_ram_model ram (.mclk, .rst_n, .slow, .dma_valid, .dma_wr, .dma_ready);

    always #50 mclk = ~mclk;

    task close_out;
        $display("Checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    // The ceiling is far above the few hundred cycles the tests need.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            close_out;
        end
    end

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        avs_write <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        rdv = avs_readdata;
        avs_read <= 1'b0;
    endtask : rd

    task rchk(input logic [3:0] a, input logic [31:0] e, input string nm);
        rd(a);
        chk(nm, rdv, e);
    endtask : rchk

    task cv(input logic [15:0] r);
        @(posedge mclk);
        conv_valid <= 1'b1;
        conv_data <= r;
        @(posedge mclk);
        conv_valid <= 1'b0;
        repeat (4) @(posedge mclk);
        while (dma_valid !== 1'b0) @(posedge mclk);
    endtask : cv

    // Returns the saturation flag above the final halved result.
    function automatic logic [16:0] corr(logic [15:0] r, o, g);
        longint p;
        logic s;
        p = (longint'($signed(r)) + longint'($signed(o))) * longint'(g);
        p = p >>> 15;
        s = p > longint'(SAT_MAX) || p < longint'($signed(SAT_MIN));
        if (p > longint'(SAT_MAX)) p = longint'(SAT_MAX);
        if (p < longint'($signed(SAT_MIN))) p = longint'($signed(SAT_MIN));
        return {s, p[15], p[15:1]};
    endfunction : corr

    function automatic logic [9:0] sel(int c);
        logic [9:0] v;
        v = 10'h000;
        if (c < 6) v[4 + c] = 1'b1;
        else if (c >= 8 && c < 12) v[c - 8] = 1'b1;
        return v;
    endfunction : sel

    task ctest(input logic [15:0] r, o, g);
        logic [16:0] e;
        e = corr(r, o, g);
        wr(REG_OFFSET, {16'h0, o});
        wr(REG_GAIN, {16'h0, g});
        wr(REG_FLAG, 32'h1F);
        cv(r);
        rd(REG_DATA);
        chk("result", rdv, e[15:0]);
        rd(REG_FLAG);
        chk("sat_flag", rdv[3:0] & 4'h9, {e[16], 3'h1});
    endtask : ctest

    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        rchk(REG_OFFSET, 32'h0, "offset");
        rchk(REG_GAIN, 32'h8000, "gain");
        wr(REG_PINCFG, 32'h0044_4440);
        repeat (3) @(posedge mclk);
        chk("digital_off", pin_digital_off, 7'h41);
        chk("vref_off", vref_out_enable, 1'b0);
        rchk(REG_PININ, 32'h53, "pin_read");
        for (int c = 0; c < 16; c++) begin
            wr(REG_CFG, 32'(c * 256 + (15 - c) * 16 + (c % 4) * 2 + 1));
            repeat (3) @(posedge mclk);
            chk("pos_sel", {pos_ext_sel, pos_int_sel}, sel(c));
            chk("neg_sel",
                {neg_ext_sel, neg_int_sel}, sel(15 - c));
            chk("bufs",
                {negative_buffer_enable, positive_buffer_enable}, c % 4);
            chk("vref_on", vref_out_enable, 1'b1);
            chk("conv_en", conv_enable, 1'b1);
        end
        wr(REG_PINCFG, 32'h0444_4440);
        repeat (3) @(posedge mclk);
        chk("vref_pin", vref_out_enable, 1'b0);
        for (int i = 0; i < 5; i++) ctest(rt[i], ot[i], gt[i]);
        wr(REG_FLAG, 32'h0);
        rd(REG_FLAG);
        chk("flag_keep", rdv[3:0] & 4'h9, 4'h9);
        wr(REG_FLAG, 32'h8);
        rd(REG_FLAG);
        chk("flag_clear", rdv[3:0] & 4'h9, 4'h1);
        wr(REG_CFG, 32'h0);
        wr(REG_FLAG, 32'h1F);
        cv(16'h0123);
        rd(REG_FLAG);
        chk("disabled", rdv[0], 1'b0);
        chk("conv_off", conv_enable, 1'b0);
        wr(REG_OFFSET, 32'h0);
        wr(REG_GAIN, 32'h8000);
        wr(REG_CFG, 32'h1);
        wr(REG_DMACFG, 32'h10);
        wr(REG_DMABEG, 32'h100);
        wr(REG_DMALEN, 32'h4);
        wr(REG_DMACFG, 32'h1);
        wr(REG_FLAG, 32'h1F);
        slow <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            cv(16'(i * 256 + 256));
            if (i == 1) begin
                rd(REG_FLAG);
                chk("half", rdv[2:1], 2'h1);
                rchk(REG_DMACUR, 32'h104, "cur");
            end
        end
        for (int i = 0; i < 4; i++)
            chk("ram", ram.mem[32'(256 + 2 * i)],
                corr(16'(i * 256 + 256), 16'h0, 16'h8000));
        rd(REG_FLAG);
        chk("full_ovf", rdv[4:2], 3'h5);
        chk("stores", ram.n_wr, 4);
        rchk(REG_DMACUR, 32'h108, "cur_end");
        wr(REG_DMACFG, 32'h1);
        rd(REG_DMACFG);
        chk("no_reset", rdv[0], 1'b0);
        slow <= 1'b0;
        wr(REG_DMACFG, 32'h10);
        rchk(REG_DMACUR, 32'h100, "cur_reset");
        wr(REG_DMALEN, 32'h2);
        wr(REG_DMACFG, 32'h3);
        rd(REG_DMACFG);
        chk("wrap_run", rdv[1:0], 2'h3);
        for (int i = 0; i < 3; i++) cv(16'(i * 256 + 2560));
        chk("wrap0", ram.mem[32'h100],
            corr(16'h0C00, 16'h0, 16'h8000));
        chk("wrap1", ram.mem[32'h102],
            corr(16'h0B00, 16'h0, 16'h8000));
        chk("stores2", ram.n_wr, 7);
        rchk(REG_DMACUR, 32'h102, "cur_wrap");
        wr(REG_CFG, 32'h0);
        cv(16'h0D00);
        chk("stopped", ram.n_wr, 7);
        close_out;
    end
endmodule : acp_adc_dma_tb
